// [rtl/pwmoim_defines.vh]
// Register indices, field positions and reset values of the output stage
`ifndef PWMOIM_DEFINES_VH
`define PWMOIM_DEFINES_VH

`define PWMOIM_CHANNELS 8
`define PWMOIM_IDX_INIT 8'h1C
`define PWMOIM_IDX_MASK 8'h1D
`define PWMOIM_IDX_SYNC_CTRL 8'h20
`define PWMOIM_IDX_POLARITY 8'h21
`define PWMOIM_IDX_INIT_CMD 8'h22
`define PWMOIM_IDX_STATUS 8'h23
`define PWMOIM_SYNC_SW_BIT 7
`define PWMOIM_SYNC_HW_SEL_BIT 6
`define PWMOIM_SYNC_MASK_SEL_BIT 3
`define PWMOIM_INIT_CMD_SW_BIT 0
`define PWMOIM_INIT_CMD_HW_EN_BIT 1
`define PWMOIM_RST_INIT 8'h00
`define PWMOIM_RST_MASK 8'h00
`define PWMOIM_RST_SYNC_CTRL 8'h00
`define PWMOIM_RST_POLARITY 8'h00
`define PWMOIM_RST_INIT_CMD 8'h00
`define PWMOIM_HTRANS_NONSEQ 2'h2
`define PWMOIM_HTRANS_SEQ 2'h3

`endif

// [rtl/pwmoim_channel.v]
// One conditioned channel output: initialization, match update and masking
`timescale 1ns/1ps
module pwmoim_channel (
	input wire hclk,
	input wire hresetn,
	input wire init_evt,
	input wire chan_init_level,
	input wire match,
	input wire match_level,
	input wire chan_output_masked,
	input wire invert,
	output reg chan_out
);

	reg level;
	reg next_level;

	always @* begin
		next_level = level;
		if (init_evt) begin
			next_level = chan_init_level;
		end else if (match && !chan_output_masked) begin
			next_level = match_level;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level <= 1'b0;
			chan_out <= 1'b0;
		end else begin
			level <= next_level;
			if (chan_output_masked) begin
				chan_out <= invert;
			end else begin
				chan_out <= next_level ^ invert;
			end
		end
	end

endmodule

// [rtl/pwmoim_ahb_slave.v]
// AHB-Lite slave front end: address capture, write strobe, one-wait reads
`timescale 1ns/1ps
`include "pwmoim_defines.vh"
module pwmoim_ahb_slave (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg wr_strobe,
	output reg rd_strobe,
	output reg [7:0] reg_idx
);

	wire take;
	reg rd_wait;

	assign take = hsel && hready &&
		(htrans == `PWMOIM_HTRANS_NONSEQ || htrans == `PWMOIM_HTRANS_SEQ);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_strobe <= 1'b0;
			rd_strobe <= 1'b0;
			rd_wait <= 1'b0;
			reg_idx <= 8'h00;
		end else begin
			hresp <= 1'b0;
			rd_strobe <= 1'b0;
			if (rd_wait) begin
				rd_wait <= 1'b0;
				hreadyout <= 1'b1;
				wr_strobe <= 1'b0;
			end else begin
				wr_strobe <= take && hwrite;
				if (take) begin
					reg_idx <= (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0)
						? haddr[9:2] : 8'hFF;
				end
				if (take && !hwrite) begin
					rd_wait <= 1'b1;
					rd_strobe <= 1'b1;
					hreadyout <= 1'b0;
				end
			end
		end
	end

endmodule

// [rtl/pwmoim_top.v]
// Channel output initialization and masking stage with its register file
`timescale 1ns/1ps
`include "pwmoim_defines.vh"
// Operation
// - Eight channels, bit n controls channel n
// - Initialization forces each output to init bit; code gives unmasked outputs init bit XOR polarity, masked ones stay inactive
// - Init bit 0 drives low, 1 high; with polarity bit 1 the code drives init bit 0 high, 1 low
// - Init register index 1Ch, mask index 1Dh
// - Mask bit 1 forces output inactive
// - Masked channel ignores compare matches
// - Mask writes go to write buffer
// - Active mask loads from buffer by synchronization
// - Mask bits reset to zero
// - Select 0 copies every clock, 1 on sync
// - Writing software sync bit raises sync trigger
module pwmoim_top (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire [7:0] chan_match,
	input wire [7:0] chan_match_level,
	input wire hw_sync_trig,
	input wire hw_init_trig,
	output wire [7:0] chan_out,
	output reg sync_event,
	output reg init_event
);

	wire wr_strobe;
	wire rd_strobe;
	wire [7:0] reg_idx;
	wire [7:0] wbyte;

	reg [7:0] channel_init_values;
	reg [7:0] mask_wbuf;
	reg [7:0] channel_output_masks;
	reg [7:0] polarity;
	reg mask_sync_select;
	reg hw_sync_select;
	reg hw_init_enable;
	reg sw_sync_pulse;
	reg sw_init_pulse;
	reg hw_sync_prev;
	reg hw_init_prev;

	wire hw_sync_rise;
	wire hw_init_rise;
	wire sync_now;
	wire init_now;

	reg [7:0] next_masks;
	reg [31:0] rd_mux;

	wire wr_init;
	wire wr_mask;
	wire wr_sync;
	wire wr_pol;
	wire wr_cmd;

	assign wbyte = hwdata[7:0];

	pwmoim_ahb_slave u_slave (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.wr_strobe(wr_strobe),
		.rd_strobe(rd_strobe),
		.reg_idx(reg_idx)
	);

	// Register decode on the word index
	assign wr_init = wr_strobe && (reg_idx == `PWMOIM_IDX_INIT);
	assign wr_mask = wr_strobe && (reg_idx == `PWMOIM_IDX_MASK);
	assign wr_sync = wr_strobe && (reg_idx == `PWMOIM_IDX_SYNC_CTRL);
	assign wr_pol = wr_strobe && (reg_idx == `PWMOIM_IDX_POLARITY);
	assign wr_cmd = wr_strobe && (reg_idx == `PWMOIM_IDX_INIT_CMD);

	// Initialization values, one bit per channel
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel_init_values <= `PWMOIM_RST_INIT;
		end else if (wr_init) begin
			channel_init_values <= wbyte;
		end
	end

	// Mask write buffer takes every software write
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_wbuf <= `PWMOIM_RST_MASK;
		end else if (wr_mask) begin
			mask_wbuf <= wbyte;
		end
	end

	// Active mask transfer from the write buffer
	always @* begin
		next_masks = channel_output_masks;
		if (!mask_sync_select) begin
			next_masks = mask_wbuf;
		end else if (sync_now) begin
			next_masks = mask_wbuf;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel_output_masks <= `PWMOIM_RST_MASK;
		end else begin
			channel_output_masks <= next_masks;
		end
	end

	// Output polarity per channel
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			polarity <= `PWMOIM_RST_POLARITY;
		end else if (wr_pol) begin
			polarity <= wbyte;
		end
	end

	// Synchronization control
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_sync_select <= 1'b0;
			hw_sync_select <= 1'b0;
			sw_sync_pulse <= 1'b0;
		end else begin
			sw_sync_pulse <= wr_sync && wbyte[`PWMOIM_SYNC_SW_BIT];
			if (wr_sync) begin
				mask_sync_select <= wbyte[`PWMOIM_SYNC_MASK_SEL_BIT];
				hw_sync_select <= wbyte[`PWMOIM_SYNC_HW_SEL_BIT];
			end
		end
	end

	// Initialization command
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hw_init_enable <= 1'b0;
			sw_init_pulse <= 1'b0;
		end else begin
			sw_init_pulse <= wr_cmd && wbyte[`PWMOIM_INIT_CMD_SW_BIT];
			if (wr_cmd) begin
				hw_init_enable <= wbyte[`PWMOIM_INIT_CMD_HW_EN_BIT];
			end
		end
	end

	// Rising edges of the trigger inputs from the timer core
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hw_sync_prev <= 1'b0;
			hw_init_prev <= 1'b0;
		end else begin
			hw_sync_prev <= hw_sync_trig;
			hw_init_prev <= hw_init_trig;
		end
	end

	assign hw_sync_rise = hw_sync_trig && !hw_sync_prev;
	assign hw_init_rise = hw_init_trig && !hw_init_prev;
	assign sync_now = sw_sync_pulse || (hw_sync_select && hw_sync_rise);
	assign init_now = sw_init_pulse || (hw_init_enable && hw_init_rise);

	// Event indications for the rest of the timer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_event <= 1'b0;
			init_event <= 1'b0;
		end else begin
			sync_event <= sync_now;
			init_event <= init_now;
		end
	end

	// Conditioned channel outputs
	genvar n;
	generate
		for (n = 0; n < `PWMOIM_CHANNELS; n = n + 1) begin : g_chan
			pwmoim_channel u_chan (
				.hclk(hclk),
				.hresetn(hresetn),
				.init_evt(init_now),
				.chan_init_level(channel_init_values[n]),
				.match(chan_match[n]),
				.match_level(chan_match_level[n]),
				.chan_output_masked(channel_output_masks[n]),
				.invert(polarity[n]),
				.chan_out(chan_out[n])
			);
		end
	endgenerate

	// Read multiplexer, sampled at the end of the read wait state
	always @* begin
		rd_mux = 32'h00000000;
		case (reg_idx)
			`PWMOIM_IDX_INIT: begin
				rd_mux[7:0] = channel_init_values;
			end
			`PWMOIM_IDX_MASK: begin
				rd_mux[7:0] = channel_output_masks;
			end
			`PWMOIM_IDX_SYNC_CTRL: begin
				rd_mux[`PWMOIM_SYNC_MASK_SEL_BIT] = mask_sync_select;
				rd_mux[`PWMOIM_SYNC_HW_SEL_BIT] = hw_sync_select;
			end
			`PWMOIM_IDX_POLARITY: begin
				rd_mux[7:0] = polarity;
			end
			`PWMOIM_IDX_INIT_CMD: begin
				rd_mux[`PWMOIM_INIT_CMD_HW_EN_BIT] = hw_init_enable;
			end
			`PWMOIM_IDX_STATUS: begin
				rd_mux[7:0] = chan_out;
			end
			default: begin
				rd_mux = 32'h00000000;
			end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_strobe) begin
			hrdata <= rd_mux;
		end
	end

endmodule

// [test/pwmoim_sva.sv]
// Bus timing and output stability checks
`timescale 1ns/1ps
module pwmoim_sva (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire [7:0] chan_match,
	input wire hw_sync_trig,
	input wire hw_init_trig,
	input wire [7:0] chan_out,
	input wire sync_event,
	input wire init_event
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
wire take = hsel && hready && htrans[1];
wire quiet = !hsel && !chan_match && !hw_sync_trig && !hw_init_trig;
a_resp_okay: assert property (!hresp) else $error("resp");
a_write_nowait: assert property (take && hwrite |=> hreadyout)
	else $error("write wait");
a_read_wait: assert property (
	take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
a_wait_short: assert property (!hreadyout |=> hreadyout)
	else $error("long wait");
a_rd_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
	else $error("hrdata moved");
a_out_hold: assert property (quiet[*4] |=> $stable(chan_out))
	else $error("output moved");
a_init_pulse: assert property (init_event |=> !init_event)
	else $error("init pulse");
a_sync_pulse: assert property (sync_event |=> !sync_event)
	else $error("sync pulse");
cover property (take && !hwrite);
cover property (init_event);
cover property (sync_event);
endmodule
bind pwmoim_top pwmoim_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .chan_match(chan_match),
	.hw_sync_trig(hw_sync_trig), .hw_init_trig(hw_init_trig),
	.chan_out(chan_out), .sync_event(sync_event), .init_event(init_event));

// [test/pwmoim_bridge.sv]
// Bridge switch model following the channel outputs
`timescale 1ns/1ps
module pwmoim_bridge (
	input wire hclk,
	input wire [7:0] gate,
	output reg [7:0] switch_on
);
always @(posedge hclk) begin
	switch_on <= gate;
end
endmodule

// [test/tb.sv]
// Self-checking bench for the output initialization and mask stage
`timescale 1ns/1ps
module tb;
logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
logic [1:0] htrans = 2'h0;
logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
logic [7:0] chan_match = 8'h0, chan_level = 8'h0;
logic hw_sync = 1'h0, hw_init = 1'h0;
wire [31:0] hrdata;
wire [7:0] chan_out, sw_on;
wire hreadyout;
wire sync_evt, init_evt;
int num_errors = 0, check_count = 0;
pwmoim_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
	.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
	.chan_match(chan_match), .chan_match_level(chan_level),
	.hw_sync_trig(hw_sync), .hw_init_trig(hw_init), .chan_out(chan_out),
	.sync_event(sync_evt), .init_event(init_evt));
pwmoim_bridge BRG (.hclk(hclk), .gate(chan_out), .switch_on(sw_on));
initial forever #10 hclk = ~hclk;
task chk(input logic [7:0] s, input logic [7:0] e);
	check_count++;
	if (s !== e) begin
		num_errors++;
		$display("Error %0t %h %h", $time, s, e);
	end
endtask
task bus(input logic w, input logic [7:0] i, input logic [31:0] d);
	hsel <= 1'h1;
	haddr <= {22'h0, i, 2'h0};
	htrans <= 2'h2;
	hwrite <= w;
	do @(posedge hclk); while (hreadyout !== 1'h1);
	hsel <= 1'h0;
	htrans <= 2'h0;
	hwdata <= d;
	do @(posedge hclk); while (hreadyout !== 1'h1);
	q = hrdata;
endtask
task step(input int n);
	repeat (n) @(posedge hclk);
	#1;
endtask
task t_init;
	logic [7:0] v;
	v = 8'hA5;
	bus(1'h0, 8'h1D, 32'h0);
	chk(q[7:0], 8'h00);
	chk(chan_out, 8'h00);
	repeat (2) begin
		bus(1'h1, 8'h1C, {24'h0, v});
		bus(1'h1, 8'h22, 32'h1);
		step(2);
		chk(chan_out, v);
		chk(sw_on, v);
		bus(1'h0, 8'h1C, 32'h0);
		chk(q[7:0], v);
		v = ~v;
	end
endtask
task t_mask_now;
	bus(1'h1, 8'h1D, 32'hF);
	bus(1'h0, 8'h1D, 32'h0);
	chk(q[7:0], 8'h0F);
	chk(chan_out, 8'h50);
	chan_match <= 8'hFF;
	chan_level <= 8'hFF;
	step(1);
	chan_match <= 8'h0;
	step(1);
	chk(chan_out, 8'hF0);
	bus(1'h1, 8'h1D, 32'h0);
	step(2);
	chk(chan_out, 8'hFA);
endtask
task t_mask_sync;
	bus(1'h1, 8'h20, 32'h8);
	bus(1'h1, 8'h1D, 32'hFF);
	step(3);
	bus(1'h0, 8'h1D, 32'h0);
	chk(q[7:0], 8'h00);
	chk(chan_out, 8'hFA);
	bus(1'h1, 8'h20, 32'h88);
	step(2);
	bus(1'h0, 8'h1D, 32'h0);
	chk(q[7:0], 8'hFF);
	chk(chan_out, 8'h00);
endtask
task t_polarity;
	bus(1'h1, 8'h21, 32'h3);
	step(3);
	chk(chan_out, 8'h03);
	bus(1'h1, 8'h30, 32'hFF);
	bus(1'h0, 8'h30, 32'h0);
	chk(q[7:0], 8'h00);
endtask
task t_hw;
	bus(1'h1, 8'h1D, 32'h0);
	hw_sync <= 1'h1;
	hw_init <= 1'h1;
	step(1);
	hw_sync <= 1'h0;
	hw_init <= 1'h0;
	step(1);
	chk(chan_out, 8'h03);
	chk({6'h00, sync_evt, init_evt}, 8'h00);
	bus(1'h1, 8'h20, 32'h48);
	bus(1'h1, 8'h1C, 32'hF);
	bus(1'h1, 8'h22, 32'h2);
	hw_sync <= 1'h1;
	step(1);
	chk({6'h00, sync_evt, init_evt}, 8'h02);
	hw_sync <= 1'h0;
	step(1);
	chk(chan_out, 8'hF9);
	hw_init <= 1'h1;
	step(1);
	chk({6'h00, sync_evt, init_evt}, 8'h01);
	chk(chan_out, 8'h0C);
	hw_init <= 1'h0;
	step(1);
	chk({6'h00, sync_evt, init_evt}, 8'h00);
endtask
task t_reset;
	bus(1'h1, 8'h1D, 32'h3C);
	hresetn <= 1'h0;
	step(2);
	chk(chan_out, 8'h00);
	hresetn <= 1'h1;
	step(1);
	bus(1'h0, 8'h1D, 32'h0);
	chk(q[7:0], 8'h00);
	bus(1'h1, 8'h1D, 32'h6);
	bus(1'h0, 8'h1D, 32'h0);
	chk(q[7:0], 8'h06);
endtask
task give_verdict;
	if (num_errors == 0 && check_count > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
initial begin
	repeat (16) @(posedge hclk);
	hresetn <= 1'h1;
	@(posedge hclk);
	t_init;
	t_mask_now;
	t_mask_sync;
	t_polarity;
	t_hw;
	t_reset;
	give_verdict;
end
initial begin
	#100000;
	num_errors++;
	give_verdict;
end
endmodule
